// ---- rtl/irfc_pkg.sv ----
// Package for the recognition-service frame codec: frame constants, timing, carriers.
// Assumes a 200 MHz system clock; the serial line rate is set by a top-level parameter.
`default_nettype none
package irfc_pkg;
  localparam int unsigned SYS_CLK_HZ      = 200_000_000;
  localparam logic [7:0]  START_CODE      = 8'h02;
  localparam logic [15:0] FRAME_KIND_CODE = 16'hFFFF;
  localparam logic [15:0] MAX_PAYLOAD_LEN = 16'h0010;
  localparam int unsigned MAX_PAYLOAD     = 16;
  localparam logic [3:0]  SVC_EXCHANGE    = 4'h0;
  localparam logic [3:0]  SVC_NOTIFY      = 4'h1;
  localparam logic [3:0]  DIR_REQUEST     = 4'h0;
  localparam logic [3:0]  DIR_RESPONSE    = 4'h8;
  localparam logic [7:0]  TAG_UNUSED      = 8'h00;
  localparam int unsigned CHAR_BITS       = 11;
  localparam int unsigned GAP_CHARS       = 3;
  localparam int unsigned SLOW_RATE_BPS   = 9600;
  localparam int unsigned SLOW_GAP_MS     = 10;
  localparam int unsigned DEFAULT_BAUD    = 9600;
  localparam int unsigned SLOW_GAP_CYCLES = SLOW_GAP_MS * (SYS_CLK_HZ / 1000);

  // Decoded frame header handed to the user with the frame
  typedef struct packed {
    logic [7:0]  command_code;
    logic [7:0]  sequence_tag;
    logic [15:0] payload_length;
  } irfc_hdr_t;

  // Byte stream element with a flag marking the last byte of the frame
  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } irfc_byte_t;
endpackage
`default_nettype wire

// ---- rtl/irfc_uart_rx.sv ----
// Character receiver: start, 8 data bits LSB first, even parity, stop.
// Assumes rx_i is already synchronised to sys_clk_i.
`default_nettype none
module irfc_uart_rx #(
  parameter int unsigned BIT_CYCLES = 20833
) (
  input  wire logic       sys_clk_i,    // System clock
  input  wire logic       reset_i,      // Sync reset
  input  wire logic       clk_en_i,     // Clock enable
  input  wire logic       rx_i,         // Synchronised line
  output logic            char_vld_o,   // Character done pulse
  output logic [7:0]      char_o,       // Data byte
  output logic            par_err_o,    // Parity or stop error
  output logic            line_idle_o   // Stop bit seen, line idle
);
  localparam int unsigned CW = $clog2(BIT_CYCLES + 1);
  localparam logic [CW-1:0] FULL = CW'(BIT_CYCLES - 1);
  localparam logic [CW-1:0] HALF = CW'(BIT_CYCLES / 2);

  logic [CW-1:0] cnt_q;
  logic [3:0]    bit_q;
  logic [9:0]    sh_q;
  logic          busy_q;
  wire           tick = (cnt_q == '0);
  wire           start_seen = !busy_q && !rx_i;
  wire           done = busy_q && tick && (bit_q == 4'hA);
  // Shift holds d0..d7, parity, stop once the last bit is in
  wire [9:0]     sh_full = {rx_i, sh_q[9:1]};
  wire           par_ok = ~^sh_full[8:0];
  wire           stop_ok = sh_full[9];

  // Bit timing samples each bit in its middle
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      cnt_q <= '0;
      bit_q <= 4'h0;
      sh_q <= 10'h000;
      busy_q <= 1'b0;
      char_vld_o <= 1'b0;
      char_o <= 8'h00;
      par_err_o <= 1'b0;
    end else if (clk_en_i) begin
      char_vld_o <= 1'b0;
      if (start_seen) begin
        busy_q <= 1'b1;
        cnt_q <= HALF;
        bit_q <= 4'h0;
      end else if (busy_q) begin
        cnt_q <= tick ? FULL : cnt_q - CW'(1);
        if (tick) begin
          if (bit_q == 4'h0 && rx_i) begin
            busy_q <= 1'b0;  // Glitch, not a start bit
          end else if (done) begin
            busy_q <= 1'b0;
            char_vld_o <= 1'b1;
            char_o <= sh_full[7:0];
            par_err_o <= !(par_ok && stop_ok);
          end else begin
            if (bit_q != 4'h0) begin
              sh_q <= {rx_i, sh_q[9:1]};
            end
            bit_q <= bit_q + 4'h1;
          end
        end
      end
    end
  end

  assign line_idle_o = !busy_q;
endmodule
`default_nettype wire

// ---- rtl/irfc_codec.sv ----
// Recognition-service frame receiver and checker, plus frame builder.
// Assumes a raw serial line on rx_pin_i and a byte sink downstream that never stalls.
`default_nettype none
module irfc_codec #(
  parameter int unsigned BAUD       = irfc_pkg::DEFAULT_BAUD,
  parameter int unsigned GAP_CYCLES = (BAUD <= irfc_pkg::SLOW_RATE_BPS) ?
                                      irfc_pkg::SLOW_GAP_CYCLES :
                                      irfc_pkg::GAP_CHARS * irfc_pkg::CHAR_BITS *
                                      (irfc_pkg::SYS_CLK_HZ / BAUD)
) (
  input  wire logic                 sys_clk_i,     // System clock 200 MHz
  input  wire logic                 reset_i,       // Sync reset, high
  input  wire logic                 clk_en_i,      // Freezes all state when low
  input  wire logic                 rx_pin_i,      // Serial line in
  output logic                      frame_ok_o,    // Valid frame pulse
  output logic                      frame_bad_o,   // Dropped frame pulse
  output irfc_pkg::irfc_hdr_t       frame_hdr_o,   // Header of last good frame
  output logic [2:0]                frame_svc_o,   // 0 none, 1 exch, 2 notify
  output logic                      frame_resp_o,  // Good frame is a response
  output logic [8*irfc_pkg::MAX_PAYLOAD-1:0] payload_bytes_o, // Payload, byte 0 low
  input  wire logic                 tx_start_i,    // Build a frame, pulse
  input  wire logic [7:0]           tx_cmd_i,      // Command code to send
  input  wire logic [7:0]           tx_tag_i,      // Tag, echo of request
  input  wire logic [4:0]           tx_len_i,      // Payload length 0..16
  input  wire logic [8*irfc_pkg::MAX_PAYLOAD-1:0] tx_payload_i, // Payload, byte 0 low
  output logic                      tx_busy_o,     // Builder active
  output logic                      tx_vld_o,      // Built byte valid
  output irfc_pkg::irfc_byte_t      tx_byte_o      // Built byte and last flag
);
  localparam int unsigned GW = $clog2(GAP_CYCLES + 1);
  localparam logic [GW-1:0] GAP_END = GW'(GAP_CYCLES);
  localparam int unsigned NP = irfc_pkg::MAX_PAYLOAD;

  typedef enum logic [2:0] {
    RX_HUNT, RX_BODY, RX_DISCARD
  } irfc_rx_st_t;

  // Two-flop sync of the serial pin
  logic sync1_q;
  logic sync2_q;
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end else if (clk_en_i) begin
      sync1_q <= rx_pin_i;
      sync2_q <= sync1_q;
    end
  end

  logic       char_vld;
  logic [7:0] char_b;
  logic       char_err;
  logic       line_idle;

  irfc_uart_rx #(
    .BIT_CYCLES (irfc_pkg::SYS_CLK_HZ / BAUD)
  ) u_rx (
    .sys_clk_i   (sys_clk_i),
    .reset_i     (reset_i),
    .clk_en_i    (clk_en_i),
    .rx_i        (sync2_q),
    .char_vld_o  (char_vld),
    .char_o      (char_b),
    .par_err_o   (char_err),
    .line_idle_o (line_idle)
  );

  irfc_rx_st_t  st_q;
  logic [GW-1:0] gap_q;
  logic [5:0]   idx_q;       // Bytes taken so far in frame
  logic [7:0]   sum_q;       // Sum of data portion
  logic [7:0]   last_q;      // Most recent byte
  logic [7:0]   prev_sum_q;  // Sum before last byte
  logic         err_q;       // Sticky frame error
  logic [15:0]  kind_q;
  logic [7:0]   cmd_q;
  logic [7:0]   tag_q;
  logic [15:0]  len_q;
  logic [8*NP-1:0] pay_q;

  // Idle gap detection from last stop bit
  wire gap_hit = (st_q == RX_BODY || st_q == RX_DISCARD) && line_idle &&
                 (gap_q == GAP_END);
  // Byte position decode, fixed header of seven bytes
  wire       in_kind  = (idx_q == 6'd1) || (idx_q == 6'd2);
  wire       in_cmd   = (idx_q == 6'd3);
  wire       in_tag   = (idx_q == 6'd4);
  wire       in_len   = (idx_q == 6'd5) || (idx_q == 6'd6);
  wire       in_pay   = (idx_q >= 6'd7);
  wire [5:0] pay_idx  = idx_q - 6'd7;
  wire       too_long = in_pay && (pay_idx > 6'(NP));
  // Checksum byte is the last one; sum of data excludes it
  wire [7:0] want_sum = 8'h00 - prev_sum_q;
  wire       sum_ok   = (last_q == want_sum);
  wire [5:0] got_pay  = idx_q - 6'd8;
  wire       count_ok = (idx_q >= 6'd8) && (len_q <= irfc_pkg::MAX_PAYLOAD_LEN) &&
                        ({10'h000, got_pay} == len_q);
  wire       kind_ok  = (kind_q == irfc_pkg::FRAME_KIND_CODE);
  wire       good     = !err_q && sum_ok && count_ok && kind_ok;
  // Service decode; reserved codes carry no meaning
  wire       svc_hi_ok = (cmd_q[7:4] == irfc_pkg::DIR_REQUEST) ||
                         (cmd_q[7:4] == irfc_pkg::DIR_RESPONSE);
  wire [2:0] svc_dec  = !svc_hi_ok ? 3'h0 :
                        (cmd_q[3:0] == irfc_pkg::SVC_EXCHANGE) ? 3'h1 :
                        (cmd_q[3:0] == irfc_pkg::SVC_NOTIFY) ? 3'h2 : 3'h0;

  // Frame receive state machine
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      st_q <= RX_HUNT;
      gap_q <= '0;
      idx_q <= 6'd0;
      sum_q <= 8'h00;
      prev_sum_q <= 8'h00;
      last_q <= 8'h00;
      err_q <= 1'b0;
      kind_q <= 16'h0000;
      cmd_q <= 8'h00;
      tag_q <= 8'h00;
      len_q <= 16'h0000;
      pay_q <= '0;
    end else if (clk_en_i) begin
      // Gap counter restarts on every character
      if (char_vld || !line_idle) begin
        gap_q <= '0;
      end else if (gap_q != GAP_END) begin
        gap_q <= gap_q + GW'(1);
      end
      case (st_q)
        RX_HUNT: begin
          if (char_vld) begin
            idx_q <= 6'd1;
            sum_q <= 8'h00;
            prev_sum_q <= 8'h00;
            err_q <= char_err;
            kind_q <= 16'h0000;
            len_q <= 16'h0000;
            // Non-start byte: swallow the rest of this burst
            st_q <= (char_b == irfc_pkg::START_CODE) ? RX_BODY : RX_DISCARD;
          end
        end
        RX_BODY: begin
          if (gap_hit) begin
            st_q <= RX_HUNT;
          end else if (char_vld) begin
            if (char_err || too_long) begin
              err_q <= 1'b1;
            end
            if (idx_q != 6'h3F) begin
              idx_q <= idx_q + 6'd1;
            end
            prev_sum_q <= sum_q;
            sum_q <= sum_q + char_b;
            last_q <= char_b;
            if (in_kind) begin
              kind_q <= {kind_q[7:0], char_b};
            end
            if (in_cmd) begin
              cmd_q <= char_b;
            end
            if (in_tag) begin
              tag_q <= char_b;
            end
            if (in_len) begin
              len_q <= {len_q[7:0], char_b};
            end
            if (in_pay && (pay_idx < 6'(NP))) begin
              pay_q[pay_idx[3:0]*8 +: 8] <= char_b;
            end
          end
        end
        RX_DISCARD: begin
          if (gap_hit) begin
            st_q <= RX_HUNT;
          end
        end
        default: begin
          st_q <= RX_HUNT;
        end
      endcase
    end
  end

  // Result outputs; bad frames raise only a local flag, nothing goes back on the line
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      frame_ok_o <= 1'b0;
      frame_bad_o <= 1'b0;
      frame_hdr_o <= '0;
      frame_svc_o <= 3'h0;
      frame_resp_o <= 1'b0;
      payload_bytes_o <= '0;
    end else if (clk_en_i) begin
      frame_ok_o <= gap_hit && (st_q == RX_BODY) && good;
      frame_bad_o <= gap_hit && !((st_q == RX_BODY) && good);
      if (gap_hit && (st_q == RX_BODY) && good) begin
        frame_hdr_o <= '{command_code: cmd_q, sequence_tag: tag_q, payload_length: len_q};
        frame_svc_o <= svc_dec;
        frame_resp_o <= (cmd_q[7:4] == irfc_pkg::DIR_RESPONSE);
        payload_bytes_o <= pay_q;
      end
    end
  end

  // Frame builder: one byte per cycle, sum accumulated as it goes
  logic [5:0]  tx_idx_q;
  logic [7:0]  tx_sum_q;
  logic [7:0]  tx_cmd_q;
  logic [7:0]  tx_tag_q;
  logic [4:0]  tx_len_q;
  logic [8*NP-1:0] tx_pay_q;
  logic        tx_act_q;
  // Length clamps at sixteen payload bytes
  wire [4:0]   tx_len_c = (tx_len_i > 5'(NP)) ? 5'(NP) : tx_len_i;
  wire [5:0]   tx_last  = 6'd7 + {1'b0, tx_len_q};
  wire [5:0]   tx_pidx  = tx_idx_q - 6'd7;
  wire [7:0]   tx_pay_b = tx_pay_q[tx_pidx[3:0]*8 +: 8];
  wire [7:0]   tx_mux   = (tx_idx_q == 6'd0) ? irfc_pkg::START_CODE :
                          (tx_idx_q == 6'd1) ? irfc_pkg::FRAME_KIND_CODE[15:8] :
                          (tx_idx_q == 6'd2) ? irfc_pkg::FRAME_KIND_CODE[7:0] :
                          (tx_idx_q == 6'd3) ? tx_cmd_q :
                          (tx_idx_q == 6'd4) ? tx_tag_q :
                          (tx_idx_q == 6'd5) ? 8'h00 :
                          (tx_idx_q == 6'd6) ? {3'h0, tx_len_q} :
                          (tx_idx_q == tx_last) ? 8'h00 - tx_sum_q :
                          tx_pay_b;
  wire [7:0]   tx_add   = (tx_idx_q == 6'd0) ? 8'h00 : tx_mux;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      tx_act_q <= 1'b0;
      tx_idx_q <= 6'd0;
      tx_sum_q <= 8'h00;
      tx_cmd_q <= 8'h00;
      tx_tag_q <= irfc_pkg::TAG_UNUSED;
      tx_len_q <= 5'd0;
      tx_pay_q <= '0;
      tx_vld_o <= 1'b0;
      tx_byte_o <= '0;
    end else if (clk_en_i) begin
      tx_vld_o <= tx_act_q;
      if (tx_act_q) begin
        tx_byte_o <= '{data: tx_mux, last: (tx_idx_q == tx_last)};
        tx_sum_q <= tx_sum_q + tx_add;
        tx_idx_q <= tx_idx_q + 6'd1;
        if (tx_idx_q == tx_last) begin
          tx_act_q <= 1'b0;
        end
      end else if (tx_start_i) begin
        // Caller supplies defined codes only and keeps request tags in 0x01..0xFF
        tx_act_q <= 1'b1;
        tx_idx_q <= 6'd0;
        tx_sum_q <= 8'h00;
        tx_cmd_q <= tx_cmd_i;
        tx_tag_q <= tx_tag_i;
        tx_len_q <= tx_len_c;
        tx_pay_q <= tx_payload_i;
      end
    end
  end

  assign tx_busy_o = tx_act_q;
endmodule
`default_nettype wire

// ---- verification/irfc_codec_assertions.sv ----
// Concurrent checks on the frame codec ports.
// Bound to every irfc_codec instance; sees only its ports.
`default_nettype none
module irfc_codec_assertions (
  input wire logic                 sys_clk_i,    // Clock
  input wire logic                 reset_i,      // Sync reset
  input wire logic                 frame_ok_o,   // Good frame pulse
  input wire logic                 frame_bad_o,  // Dropped frame pulse
  input wire irfc_pkg::irfc_hdr_t  frame_hdr_o,  // Last good header
  input wire logic [2:0]           frame_svc_o,  // Service
  input wire logic                 frame_resp_o, // Response flag
  input wire logic                 tx_start_i,   // Build request
  input wire logic [7:0]           tx_cmd_i,     // Command to send
  input wire logic [7:0]           tx_tag_i,     // Tag to send
  input wire logic [4:0]           tx_len_i,     // Length to send
  input wire logic                 tx_busy_o,    // Builder busy
  input wire logic                 tx_vld_o,     // Built byte valid
  input wire irfc_pkg::irfc_byte_t tx_byte_o     // Built byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] code_hi;
  logic [3:0] code_lo;
  logic [2:0] svc_exp;

  // Expected service decode; reserved codes map to none
  assign code_hi = frame_hdr_o.command_code[7:4];
  assign code_lo = frame_hdr_o.command_code[3:0];
  assign svc_exp = (code_hi != 4'h0 && code_hi != 4'h8) ? 3'h0 :
                   (code_lo == 4'h0) ? 3'h1 : (code_lo == 4'h1) ? 3'h2 : 3'h0;

  // One clock domain, so one default clock and reset
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  property p_excl; !(frame_ok_o && frame_bad_o); endproperty
  a_excl: assert property (p_excl) else $error("good and bad at once");
  property p_ok_pulse; frame_ok_o |=> !frame_ok_o; endproperty
  a_ok_pulse: assert property (p_ok_pulse) else $error("good pulse too long");
  property p_bad_pulse; frame_bad_o |=> !frame_bad_o; endproperty
  a_bad_pulse: assert property (p_bad_pulse) else $error("bad pulse too long");
  property p_hdr_hold; !frame_ok_o |-> $stable(frame_hdr_o); endproperty
  a_hdr_hold: assert property (p_hdr_hold) else $error("header moved");
  property p_len_max; frame_ok_o |-> frame_hdr_o.payload_length <= 16'h0010; endproperty
  a_len_max: assert property (p_len_max) else $error("length over limit");
  property p_svc;
    frame_ok_o |-> frame_svc_o == svc_exp &&
      (svc_exp == 3'h0 || frame_resp_o == (code_hi == 4'h8));
  endproperty
  a_svc: assert property (p_svc) else $error("service decode wrong");
  property p_tx_head;
    tx_start_i && !tx_busy_o |=> tx_busy_o ##1 (tx_vld_o && tx_byte_o.data == 8'h02)
      ##1 (tx_vld_o && tx_byte_o.data == 8'hFF) ##1 (tx_vld_o && tx_byte_o.data == 8'hFF);
  endproperty
  a_tx_head: assert property (p_tx_head) else $error("built header wrong");
  property p_tx_echo;
    logic [7:0] c;
    logic [7:0] t;
    (tx_start_i && !tx_busy_o, c = tx_cmd_i, t = tx_tag_i) |->
      ##5 tx_byte_o.data == c ##1 tx_byte_o.data == t;
  endproperty
  a_tx_echo: assert property (p_tx_echo) else $error("command or tag wrong");
  property p_tx_len;
    logic [4:0] l;
    (tx_start_i && !tx_busy_o && tx_len_i <= 5'h10, l = tx_len_i) |->
      ##7 tx_byte_o.data == 8'h00 ##1 tx_byte_o.data == {3'h0, l};
  endproperty
  a_tx_len: assert property (p_tx_len) else $error("length bytes wrong");
  property p_tx_last; tx_vld_o && tx_byte_o.last |=> !tx_vld_o; endproperty
  a_tx_last: assert property (p_tx_last) else $error("bytes after checksum");
  property p_tx_cause; $rose(tx_vld_o) |-> $past(tx_start_i, 2); endproperty
  a_tx_cause: assert property (p_tx_cause) else $error("unrequested send");
endmodule

bind irfc_codec irfc_codec_assertions u_chk (
  .sys_clk_i(sys_clk_i), .reset_i(reset_i), .frame_ok_o(frame_ok_o),
  .frame_bad_o(frame_bad_o), .frame_hdr_o(frame_hdr_o), .frame_svc_o(frame_svc_o),
  .frame_resp_o(frame_resp_o), .tx_start_i(tx_start_i), .tx_cmd_i(tx_cmd_i),
  .tx_tag_i(tx_tag_i), .tx_len_i(tx_len_i), .tx_busy_o(tx_busy_o),
  .tx_vld_o(tx_vld_o), .tx_byte_o(tx_byte_o)
);
`default_nettype wire

// ---- verification/irfc_host_model.sv ----
// Far-side sender: puts 11-bit characters onto the serial line.
// Assumes the bench calls send_char from a falling clock edge.
`default_nettype none
module irfc_host_model #(
  parameter int unsigned BIT_CYCLES = 20 // Clocks per bit
) (
  input  wire logic sys_clk_i, // System clock
  output logic      line_o     // Serial line, idles high
);
  timeunit 1ns;
  timeprecision 1ps;
  initial line_o = 1'b1;

  // Start 0, data LSB first, even parity, stop 1; bad flips parity
  task automatic send_char(input logic [7:0] b, input logic bad);
    logic [10:0] bits;
    bits = {1'b1, ^b ^ bad, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      line_o = bits[i];
      repeat (BIT_CYCLES) @(negedge sys_clk_i);
    end
  endtask
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// Self-checking bench for the frame codec: serial receive and frame build.
// Assumes a fast line rate so the idle gap stays short.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT = 20;
  localparam int GAP = irfc_pkg::GAP_CHARS * irfc_pkg::CHAR_BITS * BIT;
  logic                 sys_clk_i, reset_i, tx_start_i, rx_line, clk_en_i;
  logic [7:0]           tx_cmd_i, tx_tag_i;
  logic [4:0]           tx_len_i;
  logic [127:0]         tx_payload_i, payload_bytes_o;
  logic                 frame_ok_o, frame_bad_o, frame_resp_o, tx_busy_o, tx_vld_o;
  logic [2:0]           frame_svc_o;
  irfc_pkg::irfc_hdr_t  frame_hdr_o;
  irfc_pkg::irfc_byte_t tx_byte_o;
  int                   n_mismatch, checked;
  int                   freeze_n;
  logic [7:0]           fq[$];

  irfc_host_model #(.BIT_CYCLES(BIT)) host (.sys_clk_i(sys_clk_i), .line_o(rx_line));
  irfc_codec #(.BAUD(10_000_000)) DUT (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i), .rx_pin_i(rx_line),
    .frame_ok_o(frame_ok_o), .frame_bad_o(frame_bad_o), .frame_hdr_o(frame_hdr_o),
    .frame_svc_o(frame_svc_o), .frame_resp_o(frame_resp_o),
    .payload_bytes_o(payload_bytes_o), .tx_start_i(tx_start_i), .tx_cmd_i(tx_cmd_i),
    .tx_tag_i(tx_tag_i), .tx_len_i(tx_len_i), .tx_payload_i(tx_payload_i),
    .tx_busy_o(tx_busy_o), .tx_vld_o(tx_vld_o), .tx_byte_o(tx_byte_o));

  // 200 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  function automatic logic [7:0] pb(input int i);
    return 8'h11 * i[7:0] + 8'h3C;
  endfunction

  // Whole frame into fq, checksum over everything after the start code
  task automatic build(input logic [7:0] cmd, tag, input logic [15:0] len, input int n);
    logic [7:0] s;
    fq = {8'h02, 8'hFF, 8'hFF, cmd, tag, len[15:8], len[7:0]};
    for (int i = 0; i < n; i++) fq.push_back(pb(i));
    s = 8'h00;
    foreach (fq[i]) if (i > 0) s += fq[i];
    fq.push_back(8'h00 - s);
  endtask

  // Replace one byte but keep the checksum right, so only that field is off
  task automatic tweak(input int idx, input logic [7:0] v);
    fq[fq.size()-1] += fq[idx] - v;
    fq[idx] = v;
  endtask

  // Send fq back to back; bad_at picks a character with broken parity
  task automatic rx_frame(input string what, input int bad_at, input logic ok_exp);
    int n;
    foreach (fq[i]) host.send_char(fq[i], i == bad_at);
    // Freeze longer than the gap: a frame ending while frozen would time out below
    if (freeze_n > 0) begin
      clk_en_i = 1'b0;
      repeat (freeze_n) @(negedge sys_clk_i);
      clk_en_i = 1'b1;
    end
    n = 0;
    while (!frame_ok_o && !frame_bad_o && n < GAP + 200) begin
      @(negedge sys_clk_i);
      n++;
    end
    if (n >= GAP + 200) begin
      n_mismatch++;
      conclude();
    end
    check({what, " gap"}, n >= GAP - BIT && n <= GAP + BIT, 1'b1);
    check({what, " good"}, frame_ok_o, ok_exp);
    check({what, " bad"}, frame_bad_o, !ok_exp);
    @(negedge sys_clk_i);
    check({what, " once"}, frame_ok_o | frame_bad_o, 1'b0);
    check({what, " no reply"}, tx_busy_o, 1'b0);
  endtask

  task automatic t_codes();
    logic [7:0] code[6];
    logic [2:0] svc[6];
    int         len[6];
    code = '{8'h00, 8'h01, 8'h80, 8'h81, 8'h23, 8'h8F};
    svc  = '{3'h1, 3'h2, 3'h1, 3'h2, 3'h0, 3'h0};
    len  = '{16, 3, 2, 0, 5, 1};
    for (int k = 0; k < 6; k++) begin
      build(code[k], 8'hFA + k[7:0], len[k][15:0], len[k]);
      rx_frame("codes", -1, 1'b1);
      check("header", frame_hdr_o, {code[k], 8'hFA + k[7:0], len[k][15:0]});
      check("service", frame_svc_o, svc[k]);
      if (svc[k] != 3'h0) check("response", frame_resp_o, code[k][7]);
      for (int i = 0; i < len[k]; i++) check("payload", payload_bytes_o[8*i +: 8], pb(i));
    end
  endtask

  task automatic t_good();
    build(8'h00, 8'h00, 16'h0000, 0);
    rx_frame("untagged", -1, 1'b1);
    check("untagged tag", frame_hdr_o.sequence_tag, 8'h00);
    build(8'h00, 8'h05, 16'h0000, 0);
    freeze_n = GAP + BIT;
    rx_frame("request", -1, 1'b1);
    freeze_n = 0;
    check("header", frame_hdr_o, {8'h00, 8'h05, 16'h0000});
  endtask

  // Each case breaks one thing; header of the last good frame must stay
  task automatic t_errors();
    for (int k = 0; k < 6; k++) begin
      build(8'h80, 8'h01, (k == 2) ? 16'h0011 : 16'h0004, (k == 3) ? 3 : (k == 2) ? 17 : 4);
      case (k)
        0: fq[fq.size()-1] ^= 8'h01;
        4: tweak(2, 8'hFE);
        5: fq[0] = 8'h03;
        default: ;
      endcase
      rx_frame("dropped", (k == 1) ? 5 : -1, 1'b0);
      check("held header", frame_hdr_o, {8'h00, 8'h05, 16'h0000});
    end
  endtask

  // Start held two edges and tag changed late: both must be ignored
  task automatic t_tx(input logic [7:0] cmd, tag, input int len);
    logic [7:0] got[$];
    logic       lastf[$];
    build(cmd, tag, len[15:0], len);
    tx_cmd_i = cmd;
    tx_tag_i = tag;
    tx_len_i = len[4:0];
    for (int i = 0; i < 16; i++) tx_payload_i[8*i +: 8] = pb(i);
    tx_start_i = 1'b1;
    for (int n = 0; n < 40 && !(lastf.size() > 0 && lastf[$]); n++) begin
      @(negedge sys_clk_i);
      if (n == 0) tx_tag_i = ~tag;
      if (n == 1) tx_start_i = 1'b0;
      if (tx_vld_o) begin
        got.push_back(tx_byte_o.data);
        lastf.push_back(tx_byte_o.last);
      end
    end
    if (lastf.size() == 0 || !lastf[$]) begin
      n_mismatch++;
      conclude();
    end
    check("tx count", got.size(), fq.size());
    foreach (got[i]) begin
      check("tx byte", got[i], fq[i]);
      check("tx last", lastf[i], i == fq.size() - 1);
    end
    @(negedge sys_clk_i);
    check("tx idle", tx_busy_o, 1'b0);
  endtask

  initial begin
    n_mismatch = 0;
    checked = 0;
    freeze_n = 0;
    clk_en_i = 1'b1;
    reset_i = 1'b1;
    tx_start_i = 1'b0;
    tx_cmd_i = 8'h00;
    tx_tag_i = 8'h00;
    tx_len_i = 5'h00;
    tx_payload_i = '0;
    repeat (8) @(negedge sys_clk_i);
    reset_i = 1'b0;
    @(negedge sys_clk_i);
    t_codes();
    t_good();
    t_errors();
    t_tx(8'h80, 8'h05, 16);
    t_tx(8'h81, 8'h00, 0);
    conclude();
  end
endmodule
`default_nettype wire
